//--- rtl/pcst_core_regs.sv
// Program counter, return stack, time clock counter and core status registers
`timescale 1ns/1ps
`include "pcst_map.svh"

module pcst_core_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic wdt_reset,
  input wire logic wake_event,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Flow control from decoder
  input wire logic flow_valid,
  input wire pcst_pkg::pcst_flow_type flow,
  output logic flow_busy,
  // Program ROM
  output logic [10:0] rom_addr,
  // Data memory for indirect access
  output pcst_pkg::pcst_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  // Count pin and status outputs
  input wire logic count_pin,
  output logic ctrl_segment_select,
  output logic bank_select,
  output logic timer_overflow
);
  logic [10:0] pc_q, pc_d;
  logic [10:0] stack_q [`PCST_STACK_DEPTH];
  logic [`PCST_STACK_IDX_W-1:0] sp_q, sp_d;
  logic [7:0] tmr_q, tmr_d;
  logic [7:0] psctl_q;
  logic [`PCST_PSC_W-1:0] psc_q, psc_d;
  logic [7:0] bank_q;
  logic wake_q, seg_q;
  logic [2:0] pin_sync_q;
  logic pin_state_q;
  logic long_wait_q;
  logic [7:0] rdata_q;
  logic ind_rd_q;

  // Register decode
  wire wr_ind = reg_wr && reg_addr == `PCST_OFF_INDIRECT;
  wire rd_ind = reg_rd && reg_addr == `PCST_OFF_INDIRECT;
  wire wr_tmr = reg_wr && reg_addr == `PCST_OFF_TIMER;
  wire wr_pcl = reg_wr && reg_addr == `PCST_OFF_PCLOW;
  wire wr_stat = reg_wr && reg_addr == `PCST_OFF_STATUS;
  wire wr_bank = reg_wr && reg_addr == `PCST_OFF_BANKPTR;
  wire wr_psc = reg_wr && reg_addr == `PCST_OFF_PSCTRL;

  // Indirect pointer maps onto data memory
  assign mem_req.bank = bank_q[`PCST_BANK_BIT];
  assign mem_req.addr = bank_q[`PCST_RADDR_W-1:0];
  assign mem_req.wr = wr_ind;
  assign mem_req.rd = rd_ind;
  assign mem_req.wdata = reg_wdata;

  // Count pin: three flops, change accepted when last two agree
  wire pin_agree = pin_sync_q[1] == pin_sync_q[2];
  wire pin_new = pin_agree ? pin_sync_q[2] : pin_state_q;
  wire edge_fall = psctl_q[`PCST_EDGE_BIT];
  wire pin_edge = pin_agree && (pin_sync_q[2] != pin_state_q) &&
                  (edge_fall ? !pin_sync_q[2] : pin_sync_q[2]);
  wire use_pin = psctl_q[`PCST_SRC_BIT];
  wire tick = use_pin ? pin_edge : 1'b1;

  // Prescaler: ratio field selects power of two divide when assigned
  wire [3:0] ratio = psctl_q[`PCST_RATIO_W-1:0];
  wire [`PCST_PSC_W-1:0] psc_inc = psc_q + `PCST_PSC_W'(1);
  wire [`PCST_PSC_W-1:0] psc_mask = (`PCST_PSC_W'(1) << ratio) - `PCST_PSC_W'(1);
  wire psc_en = psctl_q[`PCST_PSA_BIT];
  wire psc_wrap = (psc_q & psc_mask) == psc_mask;
  wire tmr_tick = tick && (!psc_en || psc_wrap);
  wire ratio_change = wr_psc &&
                      reg_wdata[`PCST_RATIO_W-1:0] != psctl_q[`PCST_RATIO_W-1:0];
  wire any_reset = srst || wdt_reset;

  always_comb begin
    psc_d = psc_q;
    if (tick && psc_en) begin
      psc_d = psc_wrap ? '0 : psc_inc;
    end
    if (wr_tmr || ratio_change) begin
      psc_d = '0;
    end
  end

  always_comb begin
    tmr_d = tmr_q;
    if (tmr_tick) begin
      tmr_d = tmr_q + 8'h01;
    end
    if (wr_tmr) begin
      tmr_d = reg_wdata;
    end
  end

  // Program counter and stack
  wire [10:0] pc_next = pc_q + 11'h001;
  wire [`PCST_STACK_IDX_W-1:0] sp_top = sp_q - `PCST_STACK_IDX_W'(1);
  wire is_long = flow.op == pcst_pkg::PCST_OP_LONG_JUMP ||
                 flow.op == pcst_pkg::PCST_OP_LONG_CALL;
  wire do_flow = flow_valid && !flow_busy;
  wire push = do_flow && (flow.op == pcst_pkg::PCST_OP_PAGE_CALL ||
                          flow.op == pcst_pkg::PCST_OP_LONG_CALL);
  wire [10:0] page_target = {pc_q[10], flow.target[`PCST_PAGE_W-1:0]};
  wire [10:0] add_sum = pc_q + {3'b000, flow.acc};
  assign flow_busy = flow_valid && is_long && !long_wait_q;

  always_comb begin
    pc_d = pc_q;
    sp_d = sp_q;
    if (flow_busy) begin
      pc_d = pc_q;
    end else if (flow_valid) begin
      case (flow.op)
        pcst_pkg::PCST_OP_SEQ: pc_d = pc_next;
        pcst_pkg::PCST_OP_PAGE_JUMP: pc_d = page_target;
        pcst_pkg::PCST_OP_PAGE_CALL: begin
          pc_d = page_target;
          sp_d = sp_q + `PCST_STACK_IDX_W'(1);
        end
        pcst_pkg::PCST_OP_LONG_JUMP: pc_d = flow.target;
        pcst_pkg::PCST_OP_LONG_CALL: begin
          pc_d = flow.target;
          sp_d = sp_q + `PCST_STACK_IDX_W'(1);
        end
        pcst_pkg::PCST_OP_PLAIN_RETURN,
        pcst_pkg::PCST_OP_RETURN_LITERAL,
        pcst_pkg::PCST_OP_RETURN_INTERRUPT: begin
          pc_d = stack_q[sp_top];
          sp_d = sp_top;
        end
        pcst_pkg::PCST_OP_ADD_PC: pc_d = add_sum;
        default: pc_d = pc_q;
      endcase
    end
    if (wr_pcl) begin
      pc_d = {pc_q[10:8], reg_wdata};
    end
  end

  assign rom_addr = pc_q;

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `PCST_OFF_TIMER: rd_mux = tmr_q;
      `PCST_OFF_PCLOW: rd_mux = pc_q[7:0];
      `PCST_OFF_STATUS: rd_mux = {wake_q, seg_q, 6'h00};
      `PCST_OFF_BANKPTR: rd_mux = {1'b0, bank_q[6:0]};
      `PCST_OFF_PSCTRL: rd_mux = psctl_q;
      `PCST_OFF_PCHIGH: rd_mux = {5'h00, pc_q[10:8]};
      default: rd_mux = 8'h00;
    endcase
  end
  assign reg_rdata = ind_rd_q ? mem_rdata : rdata_q;

  assign ctrl_segment_select = seg_q;
  assign bank_select = bank_q[`PCST_BANK_BIT];

  // Stack storage, one entry per slot
  genvar gi;
  generate
    for (gi = 0; gi < `PCST_STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge mclk) begin
        if (srst) begin
          stack_q[gi] <= `PCST_PC_RESET;
        end else if (push && sp_q == gi) begin
          stack_q[gi] <= pc_next;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      pc_q <= `PCST_PC_RESET;
      sp_q <= '0;
      long_wait_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      long_wait_q <= flow_busy;
    end
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      psc_q <= '0;
      tmr_q <= `PCST_BYTE_RESET;
      timer_overflow <= 1'b0;
    end else begin
      psc_q <= psc_d;
      tmr_q <= tmr_d;
      timer_overflow <= tmr_tick && !wr_tmr && tmr_q == 8'hff;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_sync_q <= 3'b000;
      pin_state_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], count_pin};
      pin_state_q <= pin_new;
    end
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      psctl_q <= `PCST_BYTE_RESET;
      bank_q <= `PCST_BYTE_RESET;
      seg_q <= 1'b0;
      wake_q <= wake_event && !srst;
    end else begin
      if (wr_psc) begin
        psctl_q <= reg_wdata;
      end
      if (wr_bank) begin
        bank_q <= {1'b0, reg_wdata[6:0]};
      end
      if (wr_stat) begin
        seg_q <= reg_wdata[`PCST_STAT_SEG_BIT];
      end
      if (wake_event) begin
        wake_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 8'h00;
      ind_rd_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      ind_rd_q <= rd_ind;
    end
  end
endmodule

//--- inc/pcst_map.svh
// Register offsets, field positions, reset values and sizes of the core register block
`ifndef PCST_MAP_SVH
`define PCST_MAP_SVH
`define PCST_OFF_INDIRECT 8'h00
`define PCST_OFF_TIMER 8'h01
`define PCST_OFF_PCLOW 8'h02
`define PCST_OFF_STATUS 8'h03
`define PCST_OFF_BANKPTR 8'h04
`define PCST_OFF_PSCTRL 8'h05
`define PCST_OFF_PCHIGH 8'h06
`define PCST_PC_W 11
`define PCST_PAGE_W 10
`define PCST_STACK_DEPTH 8
`define PCST_STACK_IDX_W 3
`define PCST_PC_RESET 11'h000
`define PCST_BYTE_RESET 8'h00
`define PCST_EDGE_BIT 4
`define PCST_SRC_BIT 5
`define PCST_PSA_BIT 7
`define PCST_RATIO_W 4
`define PCST_STAT_WAKE_BIT 7
`define PCST_STAT_SEG_BIT 6
`define PCST_BANK_BIT 6
`define PCST_RADDR_W 6
`define PCST_PSC_W 16
`endif

//--- inc/pcst_pkg.sv
// Types shared by the core register block
package pcst_pkg;
  typedef enum logic [3:0] {
    PCST_OP_NONE,
    PCST_OP_SEQ,
    PCST_OP_PAGE_JUMP,
    PCST_OP_PAGE_CALL,
    PCST_OP_LONG_JUMP,
    PCST_OP_LONG_CALL,
    PCST_OP_PLAIN_RETURN,
    PCST_OP_RETURN_LITERAL,
    PCST_OP_RETURN_INTERRUPT,
    PCST_OP_ADD_PC
  } pcst_op_type;

  typedef struct packed {
    pcst_op_type op;
    logic [10:0] target;
    logic [7:0] acc;
  } pcst_flow_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcst_reg_req_type;

  typedef struct packed {
    logic bank;
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pcst_mem_req_type;
endpackage

//--- testbench/pcst_chk.sv
// Checker for the core register block ports
`timescale 1ns/1ps
module pcst_chk (
  // Clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic wdt_reset,
  input wire logic wake_event,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Flow, ROM and memory
  input wire logic flow_valid,
  input wire pcst_pkg::pcst_flow_type flow,
  input wire logic flow_busy,
  input wire logic [10:0] rom_addr,
  input wire pcst_pkg::pcst_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  // Pin and status
  input wire logic count_pin,
  input wire logic ctrl_segment_select,
  input wire logic bank_select,
  input wire logic timer_overflow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst || wdt_reset);
  wire fl = flow_valid && !reg_wr;
  wire lng = flow.op inside {pcst_pkg::PCST_OP_LONG_JUMP, pcst_pkg::PCST_OP_LONG_CALL};
  rst_pc_a: assert property (disable iff (1'b0) srst || wdt_reset |=> rom_addr == 11'h000)
    else $error("pc not cleared by reset");
  seq_step_a: assert property (fl && flow.op == pcst_pkg::PCST_OP_SEQ |=> rom_addr == $past(rom_addr) + 11'h001)
    else $error("pc did not step");
  page_jump_a: assert property (fl && flow.op == pcst_pkg::PCST_OP_PAGE_JUMP
    |=> rom_addr == {$past(rom_addr[10]), $past(flow.target[9:0])})
    else $error("page jump target wrong");
  long_hold_a: assert property (fl && lng && flow_busy |=> !flow_busy && $stable(rom_addr))
    else $error("long op first cycle wrong");
  short_op_a: assert property (fl && !lng |-> !flow_busy)
    else $error("short op stalled");
  long_load_a: assert property (fl && lng && !flow_busy |=> rom_addr == $past(flow.target))
    else $error("long target wrong");
  add_pc_a: assert property (fl && flow.op == pcst_pkg::PCST_OP_ADD_PC
    |=> rom_addr == $past(rom_addr) + {3'h0, $past(flow.acc)})
    else $error("relative add wrong");
  pc_write_a: assert property (reg_wr && reg_addr == 8'h02
    |=> rom_addr == {$past(rom_addr[10:8]), $past(reg_wdata)})
    else $error("pc low write wrong");
  indirect_a: assert property ((reg_rd || reg_wr) && reg_addr == 8'h00
    |-> mem_req.rd == reg_rd && mem_req.wr == reg_wr && mem_req.wdata == reg_wdata)
    else $error("indirect access not forwarded");
  bank_out_a: assert property (mem_req.rd || mem_req.wr |-> mem_req.bank == bank_select)
    else $error("memory bank mismatch");
  cover property (fl && flow.op == pcst_pkg::PCST_OP_LONG_CALL && !flow_busy);
  cover property (fl && flow.op == pcst_pkg::PCST_OP_RETURN_INTERRUPT);
  cover property (mem_req.rd);
endmodule
bind pcst_core_regs pcst_chk CHK (.*);

//--- testbench/pcst_mem_model.sv
// Data memory model answering indirect accesses
`timescale 1ns/1ps
module pcst_mem_model (
  // Clock
  input wire logic mclk,
  // Request and answer
  input wire pcst_pkg::pcst_mem_req_type mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [128];
  initial mem_rdata = 8'h00;
  always @(posedge mclk) begin
    if (mem_req.wr) mem[{mem_req.bank, mem_req.addr}] <= mem_req.wdata;
    if (mem_req.rd) mem_rdata <= mem[{mem_req.bank, mem_req.addr}];
    else mem_rdata <= ~mem_rdata;
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the core register block
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, srst = 1'b1, wdt_reset = 1'b0, wake_event = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, flow_valid = 1'b0, count_pin = 1'b0, rd_q = 1'b0;
  logic flow_busy, ctrl_segment_select, bank_select, timer_overflow;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata, v, w;
  logic [10:0] rom_addr, pc;
  logic [10:0] stk [8];
  logic [2:0] sp;
  pcst_pkg::pcst_flow_type flow = '0;
  pcst_pkg::pcst_mem_req_type mem_req;
  logic [7:0] exq [$];
  int errors = 0, tests_run = 0;
  always #12.5 mclk = ~mclk;
  pcst_core_regs DUT (.*);
  pcst_mem_model MEM (.*);
  task automatic chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    exq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (rd_q) chk(reg_rdata, exq.pop_front());
    rd_q <= reg_rd;
  end
  task automatic pulses(input int n);
    repeat (2 * n) begin
      count_pin <= ~count_pin;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic op(input pcst_pkg::pcst_op_type o, input logic [10:0] t, input logic [7:0] a);
    flow_valid <= 1'b1;
    flow <= '{o, t, a};
    @(posedge mclk);
    if (o inside {pcst_pkg::PCST_OP_LONG_JUMP, pcst_pkg::PCST_OP_LONG_CALL}) @(posedge mclk);
    flow_valid <= 1'b0;
    @(posedge mclk);
    if (o inside {pcst_pkg::PCST_OP_PAGE_CALL, pcst_pkg::PCST_OP_LONG_CALL}) begin
      stk[sp] = pc + 11'h001;
      sp++;
    end
    case (o)
      pcst_pkg::PCST_OP_NONE: pc = pc;
      pcst_pkg::PCST_OP_SEQ: pc = pc + 11'h001;
      pcst_pkg::PCST_OP_PAGE_JUMP, pcst_pkg::PCST_OP_PAGE_CALL: pc = {pc[10], t[9:0]};
      pcst_pkg::PCST_OP_LONG_JUMP, pcst_pkg::PCST_OP_LONG_CALL: pc = t;
      pcst_pkg::PCST_OP_ADD_PC: pc = pc + {3'h0, a};
      default: begin
        sp--;
        pc = stk[sp];
      end
    endcase
    rd(8'h02, pc[7:0]);
    rd(8'h06, {5'h00, pc[10:8]});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    results;
  end
  initial begin
    v = 8'($urandom(52));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 1; i < 8; i++) rd(8'(i), 8'h00);
    rd(8'h3f, 8'h00);
    $display("test reset done");
    v = 8'($urandom);
    wr(8'h03, v);
    rd(8'h03, {1'b0, v[6], 6'h00});
    chk({7'h00, ctrl_segment_select}, {7'h00, v[6]});
    wr(8'h04, v);
    rd(8'h04, {1'b0, v[6:0]});
    chk({7'h00, bank_select}, {7'h00, v[6]});
    wr(8'h00, ~v);
    rd(8'h00, ~v);
    wr(8'h04, v ^ 8'h40);
    wr(8'h00, v);
    rd(8'h00, v);
    wr(8'h04, v);
    rd(8'h00, ~v);
    wr(8'h03, 8'h00);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    rd(8'h03, 8'h80);
    wdt_reset <= 1'b1;
    @(posedge mclk);
    wdt_reset <= 1'b0;
    rd(8'h03, 8'h00);
    rd(8'h02, 8'h00);
    $display("test status done");
    wr(8'h05, 8'ha0);
    w = 8'($urandom);
    wr(8'h01, w);
    rd(8'h01, w);
    pulses(3);
    rd(8'h01, w + 8'h03);
    wr(8'h05, 8'hb0);
    pulses(2);
    rd(8'h01, w + 8'h05);
    wr(8'h05, 8'ha1);
    wr(8'h01, w);
    pulses(1);
    wr(8'h05, 8'ha2);
    wr(8'h05, 8'ha1);
    pulses(1);
    rd(8'h01, w);
    wr(8'h01, w);
    pulses(1);
    rd(8'h01, w);
    wr(8'h05, 8'h00);
    wr(8'h01, 8'hfd);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, timer_overflow}, 8'h01);
    @(posedge mclk);
    #1 chk({7'h00, timer_overflow}, 8'h00);
    $display("test timer done");
    pc = 11'h000;
    sp = 3'h0;
    repeat (9) op(pcst_pkg::PCST_OP_LONG_CALL, 11'($urandom), 8'h00);
    repeat (9) op(pcst_pkg::PCST_OP_PLAIN_RETURN, 11'h000, 8'h00);
    repeat (5) for (int i = 1; i < 10; i++) op(pcst_pkg::pcst_op_type'(i), 11'($urandom), 8'($urandom));
    wr(8'h02, v);
    pc = {pc[10:8], v};
    rd(8'h06, {5'h00, pc[10:8]});
    $display("test flow done");
    repeat (2) @(posedge mclk);
    results;
  end
endmodule
